// ==== dv/isa_partner.sv ====
// far side model: dma slave on the tc line and 16-bit master on refresh
`timescale 1ns/1ns
module isa_partner (
  input  wire logic eop_out,        // device drive value
  input  wire logic eop_oe_n,       // low while device drives
  input  wire logic slave_stop,     // slave wants to end the transfer
  input  wire logic refresh_out_n,  // device refresh drive value
  input  wire logic refresh_oe_n,   // low while device drives refresh
  input  wire logic master_refresh, // master wants a refresh cycle
  output logic      eop_in,         // resolved tc line
  output logic      refresh_in_n,   // resolved refresh line
  output logic      mem_row_sel     // memory steering low address onto its rows
);
  // dynamic memory sees refresh low: rows take the low address, data stays off
  assign mem_row_sel = !refresh_in_n;
  // slave only drives tc while the device has released it
  assign eop_in = !eop_oe_n ? eop_out : slave_stop;
  // refresh line is pulled up when nobody drives it
  assign refresh_in_n = !refresh_oe_n ? refresh_out_n : !master_refresh;
endmodule

// ==== dv/testbench.sv ====
// self-checking bench for the end-of-process and refresh pin logic
`timescale 1ns/1ns
module testbench;
  import eop_refresh_pkg::*;
  logic ref_clk = 0, rstn = 0, pci_reset_in = 0, dma_active = 0, addr_out = 0;
  logic count_expire = 0, autoinit = 0, aen = 0, own_refresh = 0;
  logic slave_stop = 0, master_refresh = 0, eop_in, refresh_in_n, mem_row_sel;
  logic eop_out, eop_oe_n, term_req, refresh_out_n, refresh_oe_n, ext_refresh_req;
  int err_count = 0, checked = 0;
  always #5 ref_clk = ~ref_clk;
  dma_end_refresh dut_u (.ref_clk(ref_clk), .rstn(rstn), .pci_reset_in(pci_reset_in),
    .dma_active(dma_active), .addr_out(addr_out), .count_expire(count_expire),
    .autoinit(autoinit), .aen(aen), .eop_in(eop_in), .eop_out(eop_out),
    .eop_oe_n(eop_oe_n), .term_req(term_req), .own_refresh(own_refresh),
    .refresh_in_n(refresh_in_n), .refresh_out_n(refresh_out_n),
    .refresh_oe_n(refresh_oe_n), .ext_refresh_req(ext_refresh_req));
  isa_partner far_u (.eop_out(eop_out), .eop_oe_n(eop_oe_n), .slave_stop(slave_stop),
    .refresh_out_n(refresh_out_n), .refresh_oe_n(refresh_oe_n),
    .master_refresh(master_refresh), .eop_in(eop_in), .refresh_in_n(refresh_in_n),
    .mem_row_sel(mem_row_sel));
  task automatic chk(string nm, logic e, logic g);
    checked++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %s expected %b seen %b", nm, e, g);
    end
  endtask
  // waits n edges, then lets that edge's updates land
  task automatic tk(int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic t_term;
    int k;
    @(posedge ref_clk) dma_active <= 1;
    tk(3); chk("eop_oe_n", 1, eop_oe_n);
    @(posedge ref_clk) slave_stop <= 1;
    for (k = 0; k < 6 && term_req !== 1; k++) tk(1);
    chk("term_req", 1, term_req);
    if (term_req !== 1) stop_test();
    tk(1); chk("term_req", 0, term_req);
    @(posedge ref_clk) begin slave_stop <= 0; dma_active <= 0; end
    tk(2); chk("eop_oe_n", 0, eop_oe_n);
    chk("eop_out", 0, eop_out);
    $display("termination test done");
  endtask
  task automatic t_tc(logic ai);
    @(posedge ref_clk) begin dma_active <= 1; aen <= 1; end
    tk(2);
    @(posedge ref_clk) begin addr_out <= 1; count_expire <= 1; end
    @(posedge ref_clk) begin addr_out <= 0; count_expire <= 0; end
    tk(1); chk("eop_out", 1, eop_out);
    chk("eop_oe_n", 0, eop_oe_n);
    tk(3); chk("eop_out", 1, eop_out);
    @(posedge ref_clk) if (ai) autoinit <= 1; else aen <= 0;
    tk(2); chk("eop_out", 0, eop_out);
    @(posedge ref_clk) begin aen <= 0; autoinit <= 0; dma_active <= 0; end
    tk(3); chk("eop_oe_n", 0, eop_oe_n);
    $display("terminal count test done");
  endtask
  task automatic t_ref;
    @(posedge ref_clk) own_refresh <= 1;
    tk(2); chk("refresh_oe_n", 0, refresh_oe_n);
    chk("refresh_out_n", 0, refresh_out_n);
    chk("ext_refresh_req", 0, ext_refresh_req);
    chk("mem_row_sel", 1, mem_row_sel);
    @(posedge ref_clk) pci_reset_in <= 1;
    tk(2); chk("refresh_oe_n", 1, refresh_oe_n);
    @(posedge ref_clk) begin pci_reset_in <= 0; own_refresh <= 0; end
    @(posedge ref_clk) master_refresh <= 1;
    tk(3); chk("ext_refresh_req", 1, ext_refresh_req);
    chk("refresh_oe_n", 1, refresh_oe_n);
    @(posedge ref_clk) master_refresh <= 0;
    tk(3); chk("ext_refresh_req", 0, ext_refresh_req);
    $display("refresh test done");
  endtask
  task automatic t_refuse;
    @(posedge ref_clk) begin dma_active <= 1; aen <= 1; end
    tk(2);
    @(posedge ref_clk) addr_out <= 1;
    @(posedge ref_clk) addr_out <= 0;
    tk(2);
    chk("eop_out", 0, eop_out);
    chk("eop_oe_n", 1, eop_oe_n);
    @(posedge ref_clk) begin dma_active <= 0; aen <= 0; end
    tk(2);
    chk("eop_oe_n", 0, eop_oe_n);
    @(posedge ref_clk) slave_stop <= 1;
    tk(4);
    chk("term_req", 0, term_req);
    @(posedge ref_clk) slave_stop <= 0;
    tk(1);
    $display("refusal test done");
  endtask
  task automatic t_ref_end;
    int k;
    @(posedge ref_clk) own_refresh <= 1;
    tk(4);
    chk("mem_row_sel", 1, mem_row_sel);
    @(posedge ref_clk) own_refresh <= 0;
    for (k = 0; k < 4; k++) begin
      tk(1);
      chk("ext_refresh_req", 0, ext_refresh_req);
    end
    chk("refresh_oe_n", 1, refresh_oe_n);
    chk("mem_row_sel", 0, mem_row_sel);
    $display("refresh release test done");
  endtask
  initial begin
    tk(6);
    @(posedge ref_clk) rstn <= 1;
    tk(1); chk("eop_oe_n", 0, eop_oe_n);
    chk("eop_out", 0, eop_out);
    chk("refresh_oe_n", 1, refresh_oe_n);
    t_term();
    t_tc(0);
    t_tc(1);
    t_refuse();
    t_ref();
    t_ref_end();
    stop_test();
  end
endmodule

// ==== logic/dma_end_refresh.sv ====
// end-of-process (terminal count) and refresh pin control for the isa dma engine
//
// Notes on behaviour
// R1: end_of_process pin is bidirectional, either a termination input or count output.
// R2: during every dma transfer the sampled line, when asserted, terminates the transfer; code acts on its synchronised rising edge only, not while counting.
// R3: count output asserts after a new address only if byte count expires then.
// R4: terminal count holds until aen drops; negated earlier during autoinitialization.
// R5: with no channel active the pin is an output driven low; reset starts so.
// R6: refresh output driven only while own refresh master cycle runs, held throughout.
// R7: memory steers low address to rows on refresh and drives no data then.
// R8: a 16-bit master may drive refresh in; accepted whenever not refreshing itself; ignored also under pci_reset_in and for two cycles after own release.
// R9: while pci_reset_in is asserted the refresh pin is tri-stated.
// R10: the end_of_process input is synchronised before it stops a transfer.
`timescale 1ns/1ns
module dma_end_refresh
  import eop_refresh_pkg::*;
#(
  parameter int SYNC_DEPTH = SYNC_STAGES  // flip-flops in the end_of_process synchroniser
)
(
  input  wire logic ref_clk,          // isa clock
  input  wire logic rstn,             // synchronous reset, active low
  input  wire logic pci_reset_in,     // pci reset level, active high here
  input  wire logic dma_active,       // a dma channel owns the bus
  input  wire logic addr_out,         // pulse: new address driven this cycle
  input  wire logic count_expire,     // byte count expires with this transfer
  input  wire logic autoinit,         // channel is autoinitializing
  input  wire logic aen,              // isa aen level
  input  wire logic eop_in,           // end_of_process pin level seen
  output logic      eop_out,          // end_of_process drive value
  output logic      eop_oe_n,         // low while device drives the pin
  output logic      term_req,         // pulse: slave asked to stop transfer
  input  wire logic own_refresh,      // own refresh master cycle in progress
  input  wire logic refresh_in_n,     // refresh pin level seen
  output logic      refresh_out_n,    // refresh drive value
  output logic      refresh_oe_n,     // low while device drives refresh
  output logic      ext_refresh_req   // level: external master requests refresh
);
  logic [SYNC_DEPTH-1:0] eop_sync_r;
  logic                  eop_seen_r;
  logic                  term_mode_r;
  tc_state_t             tc_state_r;
  logic                  tc_nxt;
  logic                  ref_sync0_r;
  logic                  ref_sync1_r;
  logic [1:0]            ref_drove_r;

  //////////////////////////////////////////////////////////////////////////////
  // the shift loads eop_sync_r[SYNC_DEPTH-2:0] into the stages above, so one stage is too few
  if (SYNC_DEPTH < 2) begin : g_depth_check
    $error("SYNC_DEPTH must be at least 2");
  end

  //////////////////////////////////////////////////////////////////////////////
  // count sequence state tests for the logic; tc_busy is shared with its checks
  function automatic logic tc_busy(tc_state_t st);
    return st != TC_IDLE;
  endfunction

  function automatic logic tc_holding(tc_state_t st);
    return st == TC_HOLD;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // mode: output whenever idle or counting, input while a transfer runs
  // limitation: a slave stop arriving inside the sync delay of a count is lost
  always_ff @(posedge ref_clk) begin
    if (!rstn || pci_reset_in) begin
      term_mode_r <= !RST_EOP_OUT;                              // [R5]
    end else begin
      term_mode_r <= dma_active && !tc_busy(tc_state_r);        // [R1]
    end
  end

  // synchroniser chain; each flip-flop feeds the next, and term_req also reads the last stage
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      eop_sync_r <= '0;
      eop_seen_r <= 1'h0;
    end else begin
      eop_sync_r <= {eop_sync_r[SYNC_DEPTH-2:0], eop_in};      // [R10]
      eop_seen_r <= eop_sync_r[SYNC_DEPTH-1];
    end
  end

  // rising edge only, so a slave holding the line stops one transfer once
  assign term_req = term_mode_r && dma_active
                    && eop_sync_r[SYNC_DEPTH-1] && !eop_seen_r;  // [R2]

  //////////////////////////////////////////////////////////////////////////////
  // terminal count sequence
  always_ff @(posedge ref_clk) begin
    if (!rstn || pci_reset_in) begin
      tc_state_r <= TC_IDLE;
    end else begin
      unique case (tc_state_r)
        TC_IDLE: begin
          if (dma_active && addr_out && count_expire) begin
            tc_state_r <= TC_HOLD;                              // [R3]
          end
        end
        TC_HOLD: begin
          if (!aen || autoinit) begin
            tc_state_r <= autoinit && aen ? TC_WAIT : TC_IDLE;  // [R4]
          end
        end
        TC_WAIT: begin
          if (!aen) begin
            tc_state_r <= TC_IDLE;                              // [R4]
          end
        end
        // the fourth code never occurs; fall back to idle rather than lock the pin
        default: begin
          tc_state_r <= TC_IDLE;
        end
      endcase
    end
  end

  assign tc_nxt = tc_holding(tc_state_r) && aen && !autoinit;

  always_ff @(posedge ref_clk) begin
    if (!rstn || pci_reset_in) begin
      eop_out <= EOP_IDLE;                                      // [R5]
    end else begin
      eop_out <= tc_nxt ? EOP_ACTIVE : EOP_IDLE;                // [R3] [R4]
    end
  end

  assign eop_oe_n = term_mode_r;                                // [R1] [R5]

  //////////////////////////////////////////////////////////////////////////////
  // refresh pin: drive only during own refresh, float under reset
  always_ff @(posedge ref_clk) begin
    if (!rstn || pci_reset_in) begin
      refresh_oe_n  <= 1'b1;                                    // [R9]
      refresh_out_n <= 1'b1;
    end else begin
      refresh_oe_n  <= !own_refresh;                            // [R6]
      refresh_out_n <= own_refresh ? REFRESH_ACT_N : 1'b1;      // [R6]
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      ref_sync0_r <= 1'h0;
      ref_sync1_r <= 1'h0;
    end else begin
      ref_sync0_r <= !refresh_in_n;
      ref_sync1_r <= ref_sync0_r;
    end
  end

  // the synchroniser still holds our own drive for two cycles after release,
  // so the pin is ignored until that history has drained
  // trade-off: a master driving in the very cycle we release is seen late
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      ref_drove_r <= 2'h0;
    end else begin
      ref_drove_r <= {ref_drove_r[0], !refresh_oe_n};           // [R8]
    end
  end

  // own drive would read back; ignore the pin while device refreshes
  assign ext_refresh_req = ref_sync1_r && refresh_oe_n && (ref_drove_r == 2'h0)
                           && !pci_reset_in;                    // [R8]

  //////////////////////////////////////////////////////////////////////////////
  chk_reset_refresh_float: assert property (@(posedge ref_clk) // [R9]
    pci_reset_in |=> refresh_oe_n) else $error("refresh driven in reset");
  chk_refresh_drive_own: assert property (@(posedge ref_clk) disable iff (!rstn) // [R6]
    !refresh_oe_n |-> $past(own_refresh) && !refresh_out_n)
    else $error("refresh driven without own cycle");
  chk_tc_start: assert property (@(posedge ref_clk) disable iff (!rstn || pci_reset_in) // [R3]
    $rose(eop_out) |-> $past(tc_state_r == TC_HOLD)) else $error("tc without expiry");
  chk_tc_drops_aen: assert property (@(posedge ref_clk) disable iff (!rstn) // [R4]
    eop_out |-> $past(aen)) else $error("tc held past aen");
  chk_idle_low_out: assert property (@(posedge ref_clk) disable iff (!rstn) // [R5]
    $past(!dma_active) && $past(tc_state_r == TC_IDLE) |-> !eop_oe_n && !eop_out)
    else $error("idle eop not driven low");
  chk_term_input_mode: assert property (@(posedge ref_clk) disable iff (!rstn) // [R2]
    term_req |-> eop_oe_n && dma_active) else $error("terminate outside input mode");
  chk_tc_not_in_input: assert property (@(posedge ref_clk) disable iff (!rstn) // [R1]
    eop_oe_n |-> !eop_out) else $error("tc while pin is input");
  chk_ext_ref_gated: assert property (@(posedge ref_clk) disable iff (!rstn) // [R8]
    ext_refresh_req |-> refresh_oe_n) else $error("own refresh seen as external");

  //////////////////////////////////////////////////////////////////////////////
  // multi-step behaviours, as named sequences
  sequence s_tc_start;
    !tc_busy(tc_state_r) && dma_active && addr_out && count_expire;
  endsequence

  sequence s_tc_armed;
    s_tc_start ##1 (aen && !autoinit);
  endsequence

  sequence s_ref_quiet;
    !ext_refresh_req ##1 !ext_refresh_req;
  endsequence

  // terminal count: driven after an expiring address, dropped with aen or autoinit
  chk_tc_sequence: assert property (@(posedge ref_clk) disable iff (!rstn || pci_reset_in) // [R3]
    s_tc_armed |=> eop_out && !eop_oe_n) else $error("tc not driven after expiry");
  chk_tc_release: assert property (@(posedge ref_clk) disable iff (!rstn) // [R4]
    eop_out && (!aen || autoinit) |=> !eop_out) else $error("tc kept after release");

  // refresh: held for the whole own cycle, and our own drive never reads back
  chk_refresh_held: assert property (@(posedge ref_clk) disable iff (!rstn) // [R6]
    own_refresh && !pci_reset_in |=> !refresh_oe_n && !refresh_out_n)
    else $error("own refresh not driven");
  chk_ref_release_quiet: assert property (@(posedge ref_clk) disable iff (!rstn) // [R8]
    $rose(refresh_oe_n) |-> s_ref_quiet) else $error("own refresh read back as external");

  // termination input: a synchronised edge in input mode gives exactly one pulse
  chk_term_sync_delay: assert property (@(posedge ref_clk) disable iff (!rstn) // [R10]
    term_req |-> $past(eop_in, SYNC_DEPTH) && !$past(eop_in, SYNC_DEPTH + 1))
    else $error("terminate without synchronised edge");
  chk_term_one_pulse: assert property (@(posedge ref_clk) disable iff (!rstn) // [R2]
    term_req |=> !term_req) else $error("terminate pulse too long");
endmodule

// ==== pkg/eop_refresh_pkg.sv ====
// shared constants for the end-of-process and refresh pin logic
package eop_refresh_pkg;
  localparam int  SYNC_STAGES   = 2;
  localparam bit  EOP_ACTIVE    = 1'h1;
  localparam bit  EOP_IDLE      = 1'h0;
  localparam bit  REFRESH_ACT_N = 1'h0;
  localparam bit  RST_EOP_OUT   = 1'h1;
  localparam int  CLK_PERIOD_NS = 10;
  typedef enum logic [1:0] {
    TC_IDLE,
    TC_WAIT,
    TC_HOLD
  } tc_state_t;
endpackage
